//--- hdl/gpio7_pkg.sv
/*
 * Package for the seven-bit LCD-shared GPIO port: register offsets, field
 * positions, reset values and the carrier structs shared by the port files.
 * Assumes a 32-bit Avalon-MM slave with word-aligned registers.
 */
package gpio7_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_PIN_LEVEL = 5'h00; // Pin level and latch write.
    localparam logic [4:0] OFS_LATCH     = 5'h04; // Output latch.
    localparam logic [4:0] OFS_DIRECTION = 5'h08; // Pin direction.
    localparam logic [4:0] OFS_PULLUP_G  = 5'h0C; // Pull-up enable and G pins.
    localparam logic [4:0] OFS_G_DIR     = 5'h10; // G direction and open-drain.
    localparam logic [4:0] OFS_LCD_CTRL  = 5'h14; // LCD control.
    localparam logic [4:0] OFS_SEG_BANK3 = 5'h18; // Segment enable bank 3.

    // ------------------------------------------------------------------
    // Field positions and masks.
    // ------------------------------------------------------------------
    localparam logic [7:0] PORT_MASK        = 8'hFB; // Bit 2 is absent.
    localparam int         PULLUP_EN_BIT    = 6;     // Port pull-up enable.
    localparam int         OPEN_DRAIN_BIT   = 6;     // Unit two open-drain select.
    localparam int         SEGMENT_31_DRIVE_BIT        = 7;     // Segment 31 enable.
    localparam int         PIN7             = 7;     // Shared pin index.

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DIRECTION = 8'hFB; // All implemented pins input.
    localparam logic [7:0] RST_LATCH     = 8'h00; // Latch cleared.
    localparam logic [7:0] RST_PULLUP_G  = 8'h00; // Pull-ups off.
    localparam logic [7:0] RST_OTHER     = 8'h00; // Other control registers.

    // Pin drive bundle toward the pads.
    typedef struct packed {
        logic [7:0] out;   // Level driven when enabled.
        logic [7:0] oe_n;  // Low while the pin is driven.
        logic [7:0] pull;  // Weak pull-up active.
    } pad_drive_t;

    // Avalon-MM request bundle.
    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avl_req_t;

endpackage

//--- hdl/gpio7_pin_mux.sv
/*
 * One pin's output selector. Chooses among the LCD override, unit two and
 * the latch, and forms drive, enable and pull-up for a single pad.
 * Assumes all inputs are synchronous to one clock; it is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio7_pin_mux (
    input  wire logic lcd_own_i,    // LCD common or segment owns the pin.
    input  wire logic unit_own_i,   // Unit two is routed to the pin.
    input  wire logic unit_out_i,   // Unit two compare or PWM level.
    input  wire logic open_drain_i, // Open-drain mode for unit two.
    input  wire logic dir_i,        // Direction bit, 1 is input.
    input  wire logic latch_i,      // Output latch bit.
    input  wire logic pull_en_i,    // Port-wide pull-up enable.
    output logic      out_o,        // Level to drive.
    output logic      oe_n_o,       // Low while driving.
    output logic      pull_o        // Weak pull-up on.
);
    // Output data: unit two overrides latch when it owns the pin.
    wire logic drive_data = unit_own_i ? unit_out_i : latch_i;
    // Digital drive only when LCD is idle and direction is output.
    wire logic drive_en   = !lcd_own_i && !dir_i;
    // Open-drain releases the pad whenever unit two owns the pin and its level is high.
    wire logic od_release = unit_own_i && open_drain_i && drive_data;

    assign out_o  = drive_data;
    assign oe_n_o = !(drive_en && !od_release);
    // Pull-up only for input pins with the port enable set.
    assign pull_o = pull_en_i && dir_i && !lcd_own_i;
endmodule
`default_nettype wire

//--- hdl/gpio7_port.sv
/*
 * Seven-bit GPIO port sharing pins with LCD commons, segment 31
 * and the second compare/capture unit. Registers over Avalon-MM.
 * Assumes pad inputs are synchronous to clk_i and a synchronous reset.
 */
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gpio7_port #(
    parameter int WIDTH = 8 // Pad width; the registers stay 8 bits.
) (
    input  wire logic                  clk_i,              // System clock.
    input  wire logic                  srst_i,             // Synchronous reset.
    input  wire logic [4:0]            avs_address_i,      // Byte address.
    input  wire logic                  avs_read_i,         // Read strobe.
    input  wire logic                  avs_write_i,        // Write strobe.
    input  wire logic [3:0]            avs_byteenable_i,   // Byte lanes.
    input  wire logic [31:0]           avs_writedata_i,    // Write data.
    output logic      [31:0]           avs_readdata_o,     // Read data.
    output logic                       avs_waitrequest_o,  // Stall.
    output logic      [1:0]            avs_response_o,     // 00 ok, 10 slave error.
    input  wire logic [WIDTH-1:0]      pad_in_i,           // Pad levels.
    output logic      [WIDTH-1:0]      pad_out_o,          // Pad drive levels.
    output logic      [WIDTH-1:0]      pad_oe_n_o,         // Low while driven.
    output logic      [WIDTH-1:0]      pad_pullup_o,       // Weak pull-ups.
    output logic      [3:0]            lcd_common_en_o,    // Active commons.
    output logic                       segment_31_drive_o, // Segment 31 owns pin 7.
    input  wire logic                  compare2_pin_select_i, // Config, 0 routes unit two.
    input  wire logic                  unit2_out_i,        // Unit two compare or PWM.
    input  wire logic                  unit2_mode_out_i,   // Unit two in compare/PWM mode.
    output logic                       unit2_capture_o     // Capture input from pin 7.
);
    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    logic [7:0] latch_q;      // Output latch.
    logic [7:0] dir_q;        // Direction, 1 is input.
    logic [7:0] pullup_g_q;   // Pull-up enable and G pins.
    logic [7:0] g_dir_q;      // G direction and open-drain selects.
    logic [7:0] lcd_ctrl_q;   // LCD control.
    logic [7:0] seg3_q;       // Segment enable bank 3.
    logic [31:0] rdata_q;     // Registered read data.
    logic        ack_q;       // Answer pulse.
    logic [1:0]  resp_q;      // Answer code.
    gpio7_pkg::pad_drive_t drive; // Combined pad drive.

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    wire logic req      = (avs_read_i || avs_write_i) && !ack_q;
    // A write commits at the edge that ends the request, when waitrequest is low.
    wire logic wr_go    = avs_write_i && ack_q && avs_byteenable_i[0];
    wire logic sel_port = avs_address_i == gpio7_pkg::OFS_PIN_LEVEL;
    wire logic sel_lat  = avs_address_i == gpio7_pkg::OFS_LATCH;
    wire logic sel_dir  = avs_address_i == gpio7_pkg::OFS_DIRECTION;
    wire logic sel_pu   = avs_address_i == gpio7_pkg::OFS_PULLUP_G;
    wire logic sel_gdir = avs_address_i == gpio7_pkg::OFS_G_DIR;
    wire logic sel_lcd  = avs_address_i == gpio7_pkg::OFS_LCD_CTRL;
    wire logic sel_seg  = avs_address_i == gpio7_pkg::OFS_SEG_BANK3;
    wire logic mapped   = sel_port | sel_lat | sel_dir | sel_pu | sel_gdir | sel_lcd | sel_seg;
    wire logic [7:0] wbyte = avs_writedata_i[7:0] & gpio7_pkg::PORT_MASK;

    // ------------------------------------------------------------------
    // Pin ownership.
    // ------------------------------------------------------------------
    // Commons 0..3 sit on pins 3..6; the mux field says how many are active.
    wire logic [1:0] mux_field = lcd_ctrl_q[1:0];
    always_comb begin
        case (mux_field)
            2'h0:    lcd_common_en_o = 4'h1;
            2'h1:    lcd_common_en_o = 4'h3;
            2'h2:    lcd_common_en_o = 4'h7;
            default: lcd_common_en_o = 4'hF;
        endcase
    end
    wire logic segment_31_drive_on   = seg3_q[gpio7_pkg::SEGMENT_31_DRIVE_BIT];
    wire logic unit_route = !compare2_pin_select_i;
    wire logic unit_drive = unit_route && unit2_mode_out_i;
    wire logic [7:0] lcd_own = {segment_31_drive_on, lcd_common_en_o, 3'h0};
    wire logic pull_en    = pullup_g_q[gpio7_pkg::PULLUP_EN_BIT];
    wire logic od_sel     = g_dir_q[gpio7_pkg::OPEN_DRAIN_BIT];

    // One selector per implemented pin; bit 2 stays undriven.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            if (gpio7_pkg::PORT_MASK[gi]) begin : g_impl
                gpio7_pin_mux u_mux (
                    .lcd_own_i    (lcd_own[gi]),
                    .unit_own_i   ((gi == gpio7_pkg::PIN7) && unit_drive),
                    .unit_out_i   (unit2_out_i),
                    .open_drain_i (od_sel),
                    .dir_i        (dir_q[gi]),
                    .latch_i      (latch_q[gi]),
                    .pull_en_i    (pull_en),
                    .out_o        (drive.out[gi]),
                    .oe_n_o       (drive.oe_n[gi]),
                    .pull_o       (drive.pull[gi])
                );
            end else begin : g_absent
                assign drive.out[gi]  = 1'b0;
                assign drive.oe_n[gi] = 1'b1;
                assign drive.pull[gi] = 1'b0;
            end
        end
    endgenerate

    assign pad_out_o          = drive.out;
    assign pad_oe_n_o         = drive.oe_n;
    assign pad_pullup_o       = drive.pull;
    assign segment_31_drive_o = segment_31_drive_on;
    // Capture sees pin 7 when unit two is routed and the pin is an input.
    assign unit2_capture_o    = unit_route && dir_q[gpio7_pkg::PIN7] && pad_in_i[gpio7_pkg::PIN7];

    // ------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------
    // Latch takes writes from either the port or the latch address.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            latch_q <= gpio7_pkg::RST_LATCH;
        end else if (wr_go && (sel_port || sel_lat)) begin
            latch_q <= wbyte;
        end
    end

    // Direction returns all pins to input on reset.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dir_q <= gpio7_pkg::RST_DIRECTION;
        end else if (wr_go && sel_dir) begin
            dir_q <= wbyte;
        end
    end

    // Shared control registers.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pullup_g_q <= gpio7_pkg::RST_PULLUP_G;
            g_dir_q    <= gpio7_pkg::RST_OTHER;
            lcd_ctrl_q <= gpio7_pkg::RST_OTHER;
            seg3_q     <= gpio7_pkg::RST_OTHER;
        end else if (wr_go) begin
            if (sel_pu)   pullup_g_q <= avs_writedata_i[7:0];
            if (sel_gdir) g_dir_q    <= avs_writedata_i[7:0];
            if (sel_lcd)  lcd_ctrl_q <= avs_writedata_i[7:0];
            if (sel_seg)  seg3_q     <= avs_writedata_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Read mux and answer.
    // ------------------------------------------------------------------
    // Port read returns pad levels; bit 2 forced to zero.
    logic [7:0] rmux;
    always_comb begin
        rmux = 8'h00;
        if (sel_port) rmux = pad_in_i & gpio7_pkg::PORT_MASK;
        if (sel_lat)  rmux = latch_q;
        if (sel_dir)  rmux = dir_q;
        if (sel_pu)   rmux = pullup_g_q;
        if (sel_gdir) rmux = g_dir_q;
        if (sel_lcd)  rmux = lcd_ctrl_q;
        if (sel_seg)  rmux = seg3_q;
    end

    // Every request is answered one cycle after it is seen.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q  <= 2'h0;
        end else begin
            ack_q   <= req;
            rdata_q <= req ? {24'h00_0000, rmux} : rdata_q;
            resp_q  <= req ? (mapped ? 2'h0 : 2'h2) : resp_q;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign avs_readdata_o    = rdata_q;
    assign avs_response_o    = resp_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    // A latch write is the answered cycle of a lane-0 write to either address.
    sequence s_wr_latch;
        avs_write_i && ack_q && avs_byteenable_i[0] && (sel_port || sel_lat);
    endsequence

    AST_LATCH_WRITE: assert property (@(posedge clk_i) disable iff (srst_i)
        s_wr_latch |=> latch_q == ($past(avs_writedata_i[7:0]) & gpio7_pkg::PORT_MASK))
        else $error("latch not updated by port write");
    AST_RESET_INPUT: assert property (@(posedge clk_i)
        srst_i |=> (dir_q == gpio7_pkg::RST_DIRECTION) && (pad_oe_n_o == 8'hFF))
        else $error("pins not inputs after reset");
    AST_RESET_PULL: assert property (@(posedge clk_i)
        srst_i |=> pad_pullup_o == 8'h00)
        else $error("pull-ups on after reset");
    AST_PULL_OFF: assert property (@(posedge clk_i) disable iff (srst_i)
        !pull_en |-> pad_pullup_o == 8'h00)
        else $error("pull-up on while disabled");
    AST_OUT_NOPULL: assert property (@(posedge clk_i) disable iff (srst_i)
        (pad_pullup_o & ~dir_q) == 8'h00)
        else $error("pull-up on an output pin");
    AST_BIT2: assert property (@(posedge clk_i) disable iff (srst_i)
        !latch_q[2] && !dir_q[2] && pad_oe_n_o[2])
        else $error("bit 2 is implemented");
    AST_COMMON: assert property (@(posedge clk_i) disable iff (srst_i)
        (mux_field == 2'h3) |-> (pad_oe_n_o[6:3] == 4'hF))
        else $error("common pin driven digitally");
    AST_SEGMENT_31_DRIVE: assert property (@(posedge clk_i) disable iff (srst_i)
        segment_31_drive_on |-> pad_oe_n_o[7])
        else $error("segment pin driven digitally");
    AST_UNIT_OUT: assert property (@(posedge clk_i) disable iff (srst_i)
        (unit_drive && !segment_31_drive_on && !dir_q[7] && !od_sel) |-> (pad_out_o[7] == unit2_out_i) && !pad_oe_n_o[7])
        else $error("unit two not on pin 7");
    AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (srst_i)
        (unit_drive && od_sel && unit2_out_i) |-> pad_oe_n_o[7])
        else $error("open-drain pin driven high");
    // With unit two not in an output mode the latch keeps pin 7.
    AST_LATCH_PIN7: assert property (@(posedge clk_i) disable iff (srst_i)
        (!unit2_mode_out_i && !segment_31_drive_on && !dir_q[7]) |-> (pad_out_o[7] == latch_q[7]) && !pad_oe_n_o[7])
        else $error("latch not on pin 7 with unit two idle");
    AST_ANSWER: assert property (@(posedge clk_i) disable iff (srst_i)
        req |=> !avs_waitrequest_o)
        else $error("bus answer late");
endmodule
`default_nettype wire

//--- tb/pad_model.sv
/*
 * Model of the circuits on the port pins: resolves each pad level from the
 * port drive, an external driver and the weak pull-up.
 * Assumes one clock; the bench sets which pins are externally driven.
 */
`timescale 1ns/1ps
`default_nettype none
module pad_model (
    input  wire logic       clk_i,        // System clock.
    input  wire logic [7:0] pad_out_i,    // Port drive levels.
    input  wire logic [7:0] pad_oe_n_i,   // Low while the port drives.
    input  wire logic [7:0] pad_pullup_i, // Weak pull-ups on.
    input  wire logic [7:0] ext_en_i,     // External driver active.
    input  wire logic [7:0] ext_val_i,    // External driver level.
    output logic      [7:0] pad_level_o   // Resolved pad levels.
);
    // ---------------------------------------------------------------
    // Floating lines change every cycle so a stale value never matches.
    // ---------------------------------------------------------------
    logic [7:0] float_q = 8'hA5; // Pattern for undriven, unpulled pads.

    // Toggle the floating pattern on each rising edge.
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    // Port drive wins, then an external driver, then the weak pull-up.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n_i[i]) begin
                pad_level_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_level_o[i] = ext_val_i[i];
            end else if (pad_pullup_i[i]) begin
                pad_level_o[i] = 1'h1;
            end else begin
                pad_level_o[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
 * Self-checking bench for gpio7_port: register bus tasks, a table of pin
 * configurations, then hand-written awkward cases.
 * Assumes the design package and tb/pad_model.sv are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module tb_top;
    // ---------------------------------------------------------------
    // Signals, named after the ports they meet.
    // ---------------------------------------------------------------
    logic        clk_i = 1'h0, srst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
    logic [4:0]  avs_address_i = 5'h00;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic        avs_waitrequest_o, segment_31_drive_o, unit2_capture_o;
    logic        compare2_pin_select_i = 1'h1, unit2_out_i = 1'h0, unit2_mode_out_i = 1'h1;
    logic [1:0]  avs_response_o, r;
    logic [7:0]  pad_in_i, pad_out_o, pad_oe_n_o, pad_pullup_o, q, ext_val = 8'h00, ext_en = 8'hFF;
    logic [3:0]  lcd_common_en_o;
    int          n_fail = 0, samples_checked = 0;
    typedef struct packed {
        logic [7:0] dir, lat, pu; logic [1:0] mux; logic [7:0] seg, ext, oen, out, pull, rdv; logic [3:0] com;
    } row_t;
    // Columns: direction, latch, pull-up reg, mux, segment bank, ext level, then expected pads, read level and commons.
    row_t rows [5] = '{
        '{8'h0F, 8'hA3, 8'h40, 2'h0, 8'h00, 8'h55, 8'h0F, 8'hA0, 8'h03, 8'hA1, 4'h1},
        '{8'h00, 8'hFF, 8'h40, 2'h3, 8'h80, 8'hFF, 8'hFC, 8'h03, 8'h00, 8'hFB, 4'hF},
        '{8'hFF, 8'h00, 8'h00, 2'h1, 8'h00, 8'h3C, 8'hFF, 8'h00, 8'h00, 8'h38, 4'h3},
        '{8'hFF, 8'h00, 8'h40, 2'h2, 8'h00, 8'hC3, 8'hFF, 8'h00, 8'hC3, 8'hC3, 4'h7},
        '{8'h40, 8'h40, 8'h40, 2'h0, 8'h00, 8'h00, 8'h4C, 8'h00, 8'h40, 8'h00, 4'h1}};

    // ---------------------------------------------------------------
    // Design, pad model and clock.
    // ---------------------------------------------------------------
    gpio7_port dut_u (.clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .pad_in_i, .pad_out_o,
        .pad_oe_n_o, .pad_pullup_o, .lcd_common_en_o, .segment_31_drive_o, .compare2_pin_select_i,
        .unit2_out_i, .unit2_mode_out_i, .unit2_capture_o);
    pad_model pad_u (.clk_i, .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .pad_pullup_i(pad_pullup_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(pad_in_i));
    always #20 clk_i = ~clk_i; // 25 MHz.

    // ---------------------------------------------------------------
    // Bus tasks: hold the request until waitrequest is seen low.
    // ---------------------------------------------------------------
    task automatic bus(input logic rd_en, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_read_i       <= rd_en;
        avs_write_i      <= ~rd_en;
        avs_byteenable_i <= be;
        avs_writedata_i  <= {24'h000000, d};
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'h0);
        q = avs_readdata_o[7:0];
        r = avs_response_o;
        avs_read_i  <= 1'h0;
        avs_write_i <= 1'h0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'h0, a, d, 4'h1);
    endtask
    task automatic rd(input logic [4:0] a);
        bus(1'h1, a, 8'h00, 4'hF);
    endtask
    task automatic tick2; // Let pad outputs settle after input changes.
        repeat (2) @(posedge clk_i);
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog: the whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        test_done();
    end

    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'h0;
        @(posedge clk_i);
        `CHK("oe_n rst", 8'hFF, pad_oe_n_o)
        `CHK("pull rst", 8'h00, pad_pullup_o)
        `CHK("com rst", 4'h1, lcd_common_en_o)
        rd(gpio7_pkg::OFS_DIRECTION);
        `CHK("dir rst", 8'hFB, q)
        `CHK("rsp ok", 2'h0, r)
        rd(gpio7_pkg::OFS_PULLUP_G);
        `CHK("pu rst", 8'h00, q)
        wr(gpio7_pkg::OFS_LATCH, 8'h04);
        rd(gpio7_pkg::OFS_LATCH);
        `CHK("latch bit2", 8'h00, q)
        bus(1'h0, gpio7_pkg::OFS_DIRECTION, 8'h00, 4'h0); // Lane 0 off: no effect.
        rd(gpio7_pkg::OFS_DIRECTION);
        `CHK("dir be0", 8'hFB, q)
        wr(gpio7_pkg::OFS_LATCH, 8'h5A);
        wr(gpio7_pkg::OFS_PIN_LEVEL, 8'h00);
        rd(gpio7_pkg::OFS_LATCH);
        `CHK("port clr", 8'h00, q)
        wr(gpio7_pkg::OFS_PIN_LEVEL, 8'h8B);
        rd(gpio7_pkg::OFS_LATCH);
        `CHK("port wr", 8'h8B, q)
        wr(5'h1C, 8'hFF);
        rd(5'h1C);
        `CHK("unmapped rsp", 2'h2, r)
        `CHK("unmapped data", 8'h00, q)
        // Table of ordinary pin configurations.
        for (int i = 0; i < 5; i++) begin
            wr(gpio7_pkg::OFS_DIRECTION, rows[i].dir);
            wr(gpio7_pkg::OFS_LATCH, rows[i].lat);
            wr(gpio7_pkg::OFS_PULLUP_G, rows[i].pu);
            wr(gpio7_pkg::OFS_LCD_CTRL, {6'h00, rows[i].mux});
            wr(gpio7_pkg::OFS_SEG_BANK3, rows[i].seg);
            ext_val <= rows[i].ext;
            tick2();
            `CHK("oe_n", rows[i].oen, pad_oe_n_o)
            `CHK("out", rows[i].out, pad_out_o & ~pad_oe_n_o)
            `CHK("pull", rows[i].pull, pad_pullup_o)
            `CHK("commons", rows[i].com, lcd_common_en_o)
            `CHK("segment_31_drive", rows[i].seg[7], segment_31_drive_o)
            rd(gpio7_pkg::OFS_PIN_LEVEL);
            `CHK("level", rows[i].rdv, q)
        end
        // Unit two on pin 7: override, open-drain, segment priority, routing.
        wr(gpio7_pkg::OFS_LATCH, 8'h80);
        wr(gpio7_pkg::OFS_DIRECTION, 8'h7F);
        compare2_pin_select_i <= 1'h0;
        tick2();
        `CHK("u2 out0", 2'h0, {pad_out_o[7], pad_oe_n_o[7]})
        unit2_out_i <= 1'h1;
        tick2();
        `CHK("u2 out1", 2'h2, {pad_out_o[7], pad_oe_n_o[7]})
        wr(gpio7_pkg::OFS_G_DIR, 8'h40);
        @(posedge clk_i);
        `CHK("od high", 1'h1, pad_oe_n_o[7])
        unit2_out_i <= 1'h0;
        tick2();
        `CHK("od low", 2'h0, {pad_out_o[7], pad_oe_n_o[7]})
        wr(gpio7_pkg::OFS_SEG_BANK3, 8'h80);
        @(posedge clk_i);
        `CHK("seg over u2", 1'h1, pad_oe_n_o[7])
        wr(gpio7_pkg::OFS_SEG_BANK3, 8'h00);
        wr(gpio7_pkg::OFS_G_DIR, 8'h00);
        unit2_mode_out_i <= 1'h0;
        tick2();
        `CHK("u2 idle", 2'h2, {pad_out_o[7], pad_oe_n_o[7]})
        unit2_mode_out_i <= 1'h1;
        compare2_pin_select_i <= 1'h1;
        tick2();
        `CHK("unrouted", 2'h2, {pad_out_o[7], pad_oe_n_o[7]})
        wr(gpio7_pkg::OFS_DIRECTION, 8'hFF);
        ext_val <= 8'h80;
        tick2();
        `CHK("cap unrouted", 1'h0, unit2_capture_o)
        compare2_pin_select_i <= 1'h0;
        tick2();
        `CHK("capture", 1'h1, unit2_capture_o)
        // Released pins with pull-ups read high; pin 3 stays with the LCD.
        ext_en <= 8'h00;
        tick2();
        `CHK("pull all", 8'hF3, pad_pullup_o)
        rd(gpio7_pkg::OFS_PIN_LEVEL);
        `CHK("pulled level", 8'hF3, q & 8'hF3)
        // Reset in mid-run returns every pin to input, pull-ups off.
        wr(gpio7_pkg::OFS_DIRECTION, 8'h0F);
        tick2();
        `CHK("pull pre2", 8'h03, pad_pullup_o)
        `CHK("oe_n pre2", 8'h0F, pad_oe_n_o)
        srst_i <= 1'h1;
        @(posedge clk_i);
        srst_i <= 1'h0;
        @(posedge clk_i);
        `CHK("oe_n rst2", 8'hFF, pad_oe_n_o)
        `CHK("pull rst2", 8'h00, pad_pullup_o)
        rd(gpio7_pkg::OFS_PULLUP_G);
        `CHK("pu rst2", 8'h00, q)
        test_done();
    end
endmodule
`default_nettype wire
